// ===== aio_select.sv
// auxiliary analog input routing and status output selection
`timescale 1ns/1ps
module aio_select
	import aio_pkg::*;
(
	input wire logic clk, // 100 MHz system clock
	input wire logic rstn, // asynchronous reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic [9:0] operator_analog_jack, // aux analog sample
	input wire logic high_voltage_class, // strap, caught after reset
	input wire logic [15:0] master_ref_adj, // master ref after gain/bias
	input wire logic step2_selected, // multi-step picks reference 2
	input wire logic [15:0] vf_voltage, // voltage after v/f conversion
	input wire aio_status_t drive_status, // drive conditions
	output logic [15:0] freq_ref_out, // final frequency reference
	output logic [15:0] volt_ref_out, // final output voltage
	output logic relay_contact_a, // relay no contact closed
	output logic relay_contact_b, // relay nc contact closed
	output logic transistor_output_one, // open collector one on
	output logic transistor_output_two // open collector two on
);
	logic [1:0] rst_sync_r;
	logic rst_n_q;
	aio_state_t st_r;
	aio_state_t st_nxt;
	logic req;
	logic [10:0] norm;
	logic [15:0] aux_freq;
	logic [15:0] gain_freq;
	logic [15:0] reference_offset_term_amt;
	logic [15:0] reference_offset_term_freq;
	logic [15:0] voltage_offset_term_amt;
	logic [15:0] voltage_offset_term_freq;
	logic [16:0] vb_eff;
	logic [31:0] wmask;
	logic [31:0] wval;

	function automatic logic [10:0] aux_norm(input logic [9:0] raw, input logic cur);
		logic [20:0] p;
		logic [10:0] v;
		p = '0;
		v = '0;
		if (!cur)
		begin
			v = (raw == RAW_FULL) ? NORM_FULL : {1'b0, raw};
		end
		else if (raw > CUR_ZERO)
		begin
			p = 21'(raw - CUR_ZERO) * 21'(CUR_SCALE);
			v = (p[20:10] > NORM_FULL) ? NORM_FULL : p[20:10];
		end
		return v;
	endfunction

	function automatic logic [15:0] scale(input logic [15:0] val, input logic [10:0] n);
		logic [26:0] p;
		p = 27'(val) * 27'(n);
		return p[25:10];
	endfunction

	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [16:0] b,
		input logic [15:0] lim);
		logic [17:0] s;
		s = 18'(a) + 18'(b);
		return (s > 18'(lim)) ? lim : s[15:0];
	endfunction

	function automatic logic out_sel(input logic [4:0] code, input aio_status_t s,
		input logic [15:0] thr, input logic comm);
		logic r;
		r = 1'b0;
		unique case (code)
			5'h00: r = s.drive_fault;
			5'h01: r = s.run_cmd | s.volt_active;
			5'h02: r = (s.set_freq == s.out_freq);
			5'h03: r = (s.out_freq < s.min_freq);
			5'h04: r = (s.out_freq >= thr);
			5'h05: r = (s.out_freq <= thr);
			5'h06: r = s.overtorque;
			5'h07: r = ~s.overtorque;
			5'h08: r = s.undertorque;
			5'h09: r = ~s.undertorque;
			5'h0a: r = s.minor_fault;
			5'h0b: r = s.base_blocked;
			5'h0c: r = s.local_sel;
			5'h0d: r = ~s.drive_fault & s.drive_ready;
			5'h0e: r = s.fault_retry;
			5'h0f: r = s.undervoltage_flag;
			5'h10: r = s.reverse_run;
			5'h11: r = s.speed_search;
			5'h12: r = comm;
			5'h13: r = s.pid_fb_loss;
			5'h14: r = s.fref_loss;
			5'h15: r = s.overheat_alert;
			5'h16: r = s.motor2_sel;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n_q = rst_sync_r[1];

	// relies on the outside never feeding this input to the pid loop
	assign norm = aux_norm(operator_analog_jack, st_r.aux_type);
	assign aux_freq = scale(st_r.max_freq, norm);
	assign gain_freq = scale(master_ref_adj, norm);
	assign reference_offset_term_amt = 16'((32'(st_r.max_freq) * 32'(st_r.fixed_bias)) / 32'(PERCENT_DIV));
	assign reference_offset_term_freq = sat_add(master_ref_adj, {1'b0, scale(reference_offset_term_amt, norm)},
		st_r.max_freq);
	assign voltage_offset_term_amt = scale(st_r.voltage_offset_term_full, norm);
	assign vb_eff = st_r.hv_class ? {voltage_offset_term_amt, 1'b0} : {1'b0, voltage_offset_term_amt};
	assign voltage_offset_term_freq = sat_add(vf_voltage, vb_eff, 16'hffff);
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~st_r.ack;
	assign avs_readdata = st_r.rdata;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_comb
	begin
		st_nxt = st_r;
		wval = '0;
		// strap is sampled once the reset copy is released
		if (!st_r.strap_done)
		begin
			st_nxt.hv_class = high_voltage_class;
			st_nxt.strap_done = 1'b1;
		end
		// one wait cycle per access; read data loaded during it
		st_nxt.ack = req & ~st_r.ack;
		if (avs_read && !st_r.ack)
		begin
			unique case (avs_address)
				REG_AUX_FUNC: st_nxt.rdata = {29'h0, st_r.aux_func};
				REG_AUX_TYPE: st_nxt.rdata = {31'h0, st_r.aux_type};
				REG_FIXED_BIAS: st_nxt.rdata = {26'h0, st_r.fixed_bias};
				REG_RELAY_FUNC: st_nxt.rdata = {27'h0, st_r.relay_func};
				REG_TR1_FUNC: st_nxt.rdata = {27'h0, st_r.tr1_func};
				REG_TR2_FUNC: st_nxt.rdata = {27'h0, st_r.tr2_func};
				REG_DET_THRESH: st_nxt.rdata = {16'h0, st_r.det_thresh};
				REG_STEP2: st_nxt.rdata = {16'h0, st_r.step2};
				REG_MAX_FREQ: st_nxt.rdata = {16'h0, st_r.max_freq};
				REG_VOLTAGE_OFFSET_TERM_FULL: st_nxt.rdata = {16'h0, st_r.voltage_offset_term_full};
				REG_COMM_OUT: st_nxt.rdata = {29'h0, st_r.comm_out};
				REG_STATUS: st_nxt.rdata = {27'h0, st_r.hv_class, st_r.tr2, st_r.tr1,
					~st_r.relay_a, st_r.relay_a};
				REG_FREF: st_nxt.rdata = {16'h0, st_r.fref};
				REG_VOUT: st_nxt.rdata = {16'h0, st_r.vout};
				default: st_nxt.rdata = 32'h0;
			endcase
		end
		// out-of-range function codes and bias are refused and the old value kept; aux type and comm out keep only their low bits
		if (avs_write && st_r.ack)
		begin
			unique case (avs_address)
				REG_AUX_FUNC:
				begin
					wval = (avs_writedata & wmask) | ({29'h0, st_r.aux_func} & ~wmask);
					if (wval <= 32'(AUX_FUNC_MAX))
						st_nxt.aux_func = wval[2:0];
				end
				REG_AUX_TYPE:
				begin
					if (avs_byteenable[0])
						st_nxt.aux_type = avs_writedata[0];
				end
				REG_FIXED_BIAS:
				begin
					wval = (avs_writedata & wmask) | ({26'h0, st_r.fixed_bias} & ~wmask);
					if (wval <= 32'(FIXED_BIAS_MAX))
						st_nxt.fixed_bias = wval[5:0];
				end
				REG_RELAY_FUNC:
				begin
					wval = (avs_writedata & wmask) | ({27'h0, st_r.relay_func} & ~wmask);
					if (wval <= 32'(OUT_CODE_MAX))
						st_nxt.relay_func = wval[4:0];
				end
				REG_TR1_FUNC:
				begin
					wval = (avs_writedata & wmask) | ({27'h0, st_r.tr1_func} & ~wmask);
					if (wval <= 32'(OUT_CODE_MAX))
						st_nxt.tr1_func = wval[4:0];
				end
				REG_TR2_FUNC:
				begin
					wval = (avs_writedata & wmask) | ({27'h0, st_r.tr2_func} & ~wmask);
					if (wval <= 32'(OUT_CODE_MAX))
						st_nxt.tr2_func = wval[4:0];
				end
				REG_DET_THRESH:
				begin
					wval = (avs_writedata & wmask) | ({16'h0, st_r.det_thresh} & ~wmask);
					st_nxt.det_thresh = wval[15:0];
				end
				REG_STEP2:
				begin
					wval = (avs_writedata & wmask) | ({16'h0, st_r.step2} & ~wmask);
					st_nxt.step2 = wval[15:0];
				end
				REG_MAX_FREQ:
				begin
					wval = (avs_writedata & wmask) | ({16'h0, st_r.max_freq} & ~wmask);
					st_nxt.max_freq = wval[15:0];
				end
				REG_VOLTAGE_OFFSET_TERM_FULL:
				begin
					wval = (avs_writedata & wmask) | ({16'h0, st_r.voltage_offset_term_full} & ~wmask);
					st_nxt.voltage_offset_term_full = wval[15:0];
				end
				REG_COMM_OUT:
				begin
					if (avs_byteenable[0])
						st_nxt.comm_out = avs_writedata[2:0];
				end
				default: wval = '0;
			endcase
		end
		// reference routing; unknown codes cannot be stored
		st_nxt.fref = master_ref_adj;
		st_nxt.vout = vf_voltage;
		unique case (st_r.aux_func)
			AUX_SECOND_SPEED_REFERENCE: st_nxt.fref = step2_selected ? aux_freq : master_ref_adj;
			AUX_GAIN: st_nxt.fref = gain_freq;
			AUX_REFERENCE_OFFSET_TERM: st_nxt.fref = reference_offset_term_freq;
			AUX_VOLTAGE_OFFSET_TERM: st_nxt.vout = voltage_offset_term_freq;
			default: st_nxt.fref = master_ref_adj;
		endcase
		if (st_r.aux_func != AUX_SECOND_SPEED_REFERENCE && step2_selected)
			st_nxt.fref = st_r.step2;
		// every output follows its condition on each clock
		st_nxt.relay_a = out_sel(st_r.relay_func, drive_status, st_r.det_thresh,
			st_r.comm_out[0]);
		st_nxt.tr1 = out_sel(st_r.tr1_func, drive_status, st_r.det_thresh,
			st_r.comm_out[1]);
		st_nxt.tr2 = out_sel(st_r.tr2_func, drive_status, st_r.det_thresh,
			st_r.comm_out[2]);
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			st_r <= '0;
			st_r.aux_func <= AUX_FUNC_RST;
			st_r.fixed_bias <= FIXED_BIAS_RST;
			st_r.relay_func <= RELAY_FUNC_RST;
			st_r.tr1_func <= TR1_FUNC_RST;
			st_r.tr2_func <= TR2_FUNC_RST;
			st_r.max_freq <= MAX_FREQ_RST;
			st_r.voltage_offset_term_full <= VOLTAGE_OFFSET_TERM_FULL_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign freq_ref_out = st_r.fref;
	assign volt_ref_out = st_r.vout;
	assign relay_contact_a = st_r.relay_a;
	assign relay_contact_b = ~st_r.relay_a;
	assign transistor_output_one = st_r.tr1;
	assign transistor_output_two = st_r.tr2;

	a_func_off_pass: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.aux_func == AUX_OFF && !step2_selected && $stable(st_r.aux_func))
		|=> freq_ref_out == $past(master_ref_adj))
		else $error("aux input not ignored when disabled");
	a_second_speed_reference_aux: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.aux_func == AUX_SECOND_SPEED_REFERENCE && step2_selected)
		|=> freq_ref_out == $past(aux_freq))
		else $error("second reference not taken from aux input");
	a_gain_mult: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.aux_func == AUX_GAIN && norm == NORM_FULL)
		|=> freq_ref_out == $past(master_ref_adj))
		else $error("full gain changed the reference");
	a_bias_range: assert property (@(posedge clk) disable iff (!rst_n_q)
		st_r.fixed_bias <= FIXED_BIAS_MAX)
		else $error("fixed bias out of range");
	a_voltage_offset_term_off: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.aux_func != AUX_VOLTAGE_OFFSET_TERM && $stable(st_r.aux_func))
		|=> volt_ref_out == $past(vf_voltage))
		else $error("voltage offset applied outside function 4");
	a_relay_pair: assert property (@(posedge clk) disable iff (!rst_n_q)
		relay_contact_b != relay_contact_a)
		else $error("relay contacts not complementary");
	a_relay_fault: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.relay_func == 5'h00 && $stable(st_r.relay_func))
		|=> relay_contact_a == $past(drive_status.drive_fault))
		else $error("relay does not follow fault");
	a_det_thresh: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.tr1_func == 5'h04 && $stable(st_r.tr1_func)
		&& $stable(st_r.det_thresh))
		|=> transistor_output_one
		== ($past(drive_status.out_freq) >= $past(st_r.det_thresh)))
		else $error("frequency detection wrong");
	a_comm_out: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rst_n_q && st_r.tr2_func == 5'h12 && $stable(st_r.tr2_func))
		|=> transistor_output_two == $past(st_r.comm_out[2]))
		else $error("output two ignores communication value");
	a_voltage_offset_term_double: assert property (@(posedge clk) disable iff (!rst_n_q)
		(st_r.hv_class && st_r.strap_done) |-> vb_eff == {voltage_offset_term_amt, 1'b0})
		else $error("voltage offset not doubled");
endmodule

// ===== aio_pkg.sv
// constants and types for the auxiliary input and status output selector
package aio_pkg;
	localparam logic [7:0] REG_AUX_FUNC = 8'h00;
	localparam logic [7:0] REG_AUX_TYPE = 8'h04;
	localparam logic [7:0] REG_FIXED_BIAS = 8'h08;
	localparam logic [7:0] REG_RELAY_FUNC = 8'h0c;
	localparam logic [7:0] REG_TR1_FUNC = 8'h10;
	localparam logic [7:0] REG_TR2_FUNC = 8'h14;
	localparam logic [7:0] REG_DET_THRESH = 8'h18;
	localparam logic [7:0] REG_STEP2 = 8'h1c;
	localparam logic [7:0] REG_MAX_FREQ = 8'h20;
	localparam logic [7:0] REG_VOLTAGE_OFFSET_TERM_FULL = 8'h24;
	localparam logic [7:0] REG_COMM_OUT = 8'h28;
	localparam logic [7:0] REG_STATUS = 8'h2c;
	localparam logic [7:0] REG_FREF = 8'h30;
	localparam logic [7:0] REG_VOUT = 8'h34;
	localparam logic [2:0] AUX_FUNC_MAX = 3'h4;
	localparam logic [2:0] AUX_FUNC_RST = 3'h0;
	localparam logic [5:0] FIXED_BIAS_MAX = 6'h32;
	localparam logic [5:0] FIXED_BIAS_RST = 6'h0a;
	localparam logic [4:0] OUT_CODE_MAX = 5'h16;
	localparam logic [4:0] RELAY_FUNC_RST = 5'h00;
	localparam logic [4:0] TR1_FUNC_RST = 5'h01;
	localparam logic [4:0] TR2_FUNC_RST = 5'h02;
	localparam logic [15:0] MAX_FREQ_RST = 16'h1770;
	localparam logic [15:0] VOLTAGE_OFFSET_TERM_FULL_RST = 16'h0064;
	localparam logic [15:0] PERCENT_DIV = 16'h0064;
	localparam logic [9:0] CUR_ZERO = 10'h0cd;
	localparam logic [10:0] CUR_SCALE = 11'h500;
	localparam logic [10:0] NORM_FULL = 11'h400;
	localparam logic [9:0] RAW_FULL = 10'h3ff;
	typedef enum logic [2:0] {
		AUX_OFF = 3'b000,
		AUX_SECOND_SPEED_REFERENCE = 3'b001,
		AUX_GAIN = 3'b010,
		AUX_REFERENCE_OFFSET_TERM = 3'b011,
		AUX_VOLTAGE_OFFSET_TERM = 3'b100
	} aio_aux_func_t;
	typedef struct packed {
		logic drive_fault;
		logic run_cmd;
		logic volt_active;
		logic minor_fault;
		logic base_blocked;
		logic local_sel;
		logic drive_ready;
		logic fault_retry;
		logic undervoltage_flag;
		logic reverse_run;
		logic speed_search;
		logic overtorque;
		logic undertorque;
		logic pid_fb_loss;
		logic fref_loss;
		logic overheat_alert;
		logic motor2_sel;
		logic [15:0] set_freq;
		logic [15:0] out_freq;
		logic [15:0] min_freq;
	} aio_status_t;
	typedef struct packed {
		logic [2:0] aux_func;
		logic aux_type;
		logic [5:0] fixed_bias;
		logic [4:0] relay_func;
		logic [4:0] tr1_func;
		logic [4:0] tr2_func;
		logic [15:0] det_thresh;
		logic [15:0] step2;
		logic [15:0] max_freq;
		logic [15:0] voltage_offset_term_full;
		logic [2:0] comm_out;
		logic hv_class;
		logic strap_done;
		logic ack;
		logic [31:0] rdata;
		logic relay_a;
		logic tr1;
		logic tr2;
		logic [15:0] fref;
		logic [15:0] vout;
	} aio_state_t;
endpackage

// ===== aio_ctl_model.sv
// far-side equipment that reads the relay and open-collector outputs
`timescale 1ns/1ps
module aio_ctl_model
(
	input wire logic clk, // system clock
	input wire logic relay_a, // relay no contact
	input wire logic relay_b, // relay nc contact
	input wire logic out_one, // open collector one
	input wire logic out_two, // open collector two
	output logic [2:0] seen_r // last sample {two, one, relay}
);
	// relay only counts as closed when both contacts agree
	always_ff @(posedge clk)
	begin
		seen_r <= {out_two, out_one, relay_a & ~relay_b};
	end
endmodule

// ===== aio_select_bench.sv
// self-checking bench for the aux input and status output selector
`timescale 1ns/1ps
module aio_select_bench
	import aio_pkg::*;
;
	localparam logic [15:0] THR = 16'h0100;
	logic clk;
	logic rstn;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [9:0] jack;
	logic hv;
	logic [15:0] master;
	logic step2_sel;
	logic [15:0] vf;
	aio_status_t st;
	aio_status_t pat [3];
	logic [15:0] fref;
	logic [15:0] vout;
	logic ra;
	logic rb;
	logic t1;
	logic t2;
	logic [2:0] seen;
	logic [2:0] e;
	int errors;
	int num_checks;
	int cycles;

	aio_select i_aio_select (.clk(clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.operator_analog_jack(jack), .high_voltage_class(hv), .master_ref_adj(master),
		.step2_selected(step2_sel), .vf_voltage(vf), .drive_status(st),
		.freq_ref_out(fref), .volt_ref_out(vout), .relay_contact_a(ra),
		.relay_contact_b(rb), .transistor_output_one(t1), .transistor_output_two(t2));

	aio_ctl_model i_aio_ctl_model (.clk(clk), .relay_a(ra), .relay_b(rb), .out_one(t1),
		.out_two(t2), .seen_r(seen));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// generous ceiling, the whole run needs under 5000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// request held until a rising edge sees waitrequest low; data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic settle();
		@(posedge clk);
		@(negedge clk);
	endtask

	task automatic reset_seq(input logic strap);
		@(posedge clk);
		rstn <= 1'b0;
		hv <= strap;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	function automatic logic exp_out(input logic [4:0] c, input aio_status_t s, input logic cm);
		logic [22:0] v;
		v = {s.motor2_sel, s.overheat_alert, s.fref_loss, s.pid_fb_loss,
			cm, s.speed_search, s.reverse_run, s.undervoltage_flag, s.fault_retry,
			s.drive_ready & ~s.drive_fault, s.local_sel, s.base_blocked, s.minor_fault,
			~s.undertorque, s.undertorque, ~s.overtorque, s.overtorque,
			s.out_freq <= THR, s.out_freq >= THR, s.out_freq < s.min_freq,
			s.set_freq == s.out_freq, s.run_cmd | s.volt_active, s.drive_fault};
		return v[c];
	endfunction

	initial
	begin
		errors = 0;
		num_checks = 0;
		cycles = 0;
		rstn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		jack = 10'h200;
		hv = 1'b1;
		master = 16'h1000;
		step2_sel = 1'b0;
		vf = 16'h0200;
		st = '0;
		pat[0] = '0;
		pat[1] = {17'h1ffff, 16'h0100, 16'h0100, 16'h0050};
		pat[2] = {17'h0a5a5, 16'h0090, 16'h0080, 16'h0100};
		reset_seq(1'b1);
		rd(REG_AUX_FUNC, 32'h0);
		rd(REG_AUX_TYPE, 32'h0);
		rd(REG_FIXED_BIAS, 32'h0a);
		rd(REG_RELAY_FUNC, 32'h0);
		rd(REG_TR1_FUNC, 32'h1);
		rd(REG_TR2_FUNC, 32'h2);
		rd(8'h3c, 32'h0);
		wr(REG_AUX_FUNC, 32'h5);
		rd(REG_AUX_FUNC, 32'h0);
		wr(REG_FIXED_BIAS, 32'h33);
		rd(REG_FIXED_BIAS, 32'h0a);
		wr(REG_RELAY_FUNC, 32'h17);
		rd(REG_RELAY_FUNC, 32'h0);
		// aux routing, jack at half scale on voltage input, then current input and jack end points
		wr(REG_STEP2, 32'h0abc);
		step2_sel <= 1'b1;
		settle();
		chk({fref, vout}, 32'h0abc0200);
		wr(REG_AUX_FUNC, 32'h1);
		settle();
		chk({16'h0, fref}, 32'h0bb8);
		step2_sel <= 1'b0;
		wr(REG_AUX_FUNC, 32'h2);
		settle();
		chk({16'h0, fref}, 32'h0800);
		wr(REG_AUX_FUNC, 32'h3);
		settle();
		chk({16'h0, fref}, 32'h112c);
		wr(REG_FIXED_BIAS, 32'h32);
		settle();
		chk({16'h0, fref}, 32'h15dc);
		wr(REG_AUX_FUNC, 32'h4);
		settle();
		chk({16'h0, vout}, 32'h0264);
		wr(REG_AUX_TYPE, 32'h1);
		wr(REG_AUX_FUNC, 32'h2);
		jack <= 10'h3ff;
		settle();
		chk({16'h0, fref}, 32'h0ff8);
		@(posedge clk);
		jack <= 10'h0cd;
		settle();
		chk({16'h0, fref}, 32'h0);
		wr(REG_AUX_TYPE, 32'h0);
		jack <= 10'h3ff;
		settle();
		chk({16'h0, fref}, 32'h1000);
		// every output code on three status patterns, one code per terminal
		wr(REG_DET_THRESH, {16'h0, THR});
		wr(REG_COMM_OUT, 32'h5);
		for (int c = 0; c < 23; c++)
		begin
			wr(REG_RELAY_FUNC, 32'(c));
			wr(REG_TR1_FUNC, 32'((c + 1) % 23));
			wr(REG_TR2_FUNC, 32'((c + 2) % 23));
			for (int p = 0; p < 3; p++)
			begin
				@(posedge clk);
				st <= pat[p];
				@(posedge clk);
				settle();
				e[0] = exp_out(5'(c), pat[p], 1'b1);
				e[1] = exp_out(5'((c + 1) % 23), pat[p], 1'b0);
				e[2] = exp_out(5'((c + 2) % 23), pat[p], 1'b1);
				chk({25'h0, rb, t2, t1, ra, seen}, {25'h0, ~e[0], e, e});
			end
		end
		// low-voltage strap: offset not doubled
		jack <= 10'h200;
		reset_seq(1'b0);
		wr(REG_AUX_FUNC, 32'h4);
		settle();
		chk({16'h0, vout}, 32'h0232);
		rd(REG_STATUS, 32'h6);
		rd(REG_VOUT, 32'h232);
		report_and_stop();
	end
endmodule
